// ---- hdl/pin_function_control.sv ----
// Pin function control: hold pin, fault pin and two general outputs.
// Assumes one clock, a plain register strobe port and external pin pads.
//
// How it works
// - Hold input enable bit 11, resets one
// - Normal hold: low pin holds converter reset
// - Alternate hold only with several channels
// - Alternate: low at switch delays next conversion
// - Fault mode bits 10:9, 00 unused
// - Mode 01: inverted input feeds fault flag
// - Mode 10: OR of errors, open-drain low
// - Mode 11: pin follows fault data bit
// - Fault data bit 8: output level, input readback
// - Bit 7 drives second general output
// - Bit 6 drives first general output
// - Bit 13 enables both general outputs
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pin_function_control #(
  parameter int ERR_WIDTH = 4
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire pin_function_pkg::reg_req_t req,
  output logic [15:0]                    rdata,
  input  wire logic                      hold_pin_n,
  input  wire logic                      fault_pin_in,
  output pin_function_pkg::pin_drive_t   fault_pin,
  output logic                           fault_pullup_en,
  output logic                           general_output_0,
  output logic                           general_output_0_en,
  output logic                           general_output_1,
  output logic                           general_output_1_en,
  input  wire logic                      multi_channel,
  input  wire logic                      channel_switch_due,
  input  wire logic [ERR_WIDTH-1:0]      internal_errors,
  output logic                           converter_reset,
  output logic                           start_conversion,
  output logic                           converter_fault,
  output logic                           irq
);

  logic [15:0]                          pin_config_reg;
  logic                                 alternate_hold_mode_reg;
  logic [pin_function_pkg::IRQ_WIDTH-1:0] int_status_reg;
  logic [pin_function_pkg::IRQ_WIDTH-1:0] int_mask_reg;
  logic                                 hold_meta_reg;
  logic                                 hold_sync_reg;
  logic                                 hold_last_reg;
  logic                                 fault_meta_reg;
  logic                                 fault_sync_reg;
  logic                                 waiting_reg;
  logic                                 fault_last_reg;
  logic [15:0]                          rdata_next;
  logic [pin_function_pkg::IRQ_WIDTH-1:0] events;
  pin_function_pkg::fault_mode_t        fault_mode;
  logic                                 hold_enable;
  logic                                 alt_active;
  logic                                 fault_input_level;
  logic                                 any_error;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  // Field decode
  // fault mode field
  assign fault_mode  = pin_function_pkg::fault_mode_t'(
    pin_config_reg[pin_function_pkg::FAULT_MODE_HI:
                   pin_function_pkg::FAULT_MODE_LO]);
  assign hold_enable = pin_config_reg[pin_function_pkg::HOLD_ENABLE_BIT];
  assign alt_active  = alternate_hold_mode_reg && multi_channel;

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_meta_reg  <= 1'b1;
      hold_sync_reg  <= 1'b1;
      fault_meta_reg <= 1'b1;
      fault_sync_reg <= 1'b1;
    end else begin
      hold_meta_reg  <= hold_pin_n;
      hold_sync_reg  <= hold_meta_reg;
      fault_meta_reg <= fault_pin_in;
      fault_sync_reg <= fault_meta_reg;
    end
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_config_reg          <= pin_function_pkg::PIN_CONFIG_RESET;
      alternate_hold_mode_reg <= 1'b0;
      int_mask_reg            <= '0;
    end else if (req.wr) begin
      if (hit(req.addr, pin_function_pkg::PIN_CONFIG_ADDR)) begin
        pin_config_reg <= req.wdata & pin_function_pkg::PIN_CONFIG_WMASK;
      end
      if (hit(req.addr, pin_function_pkg::HOLD_CTRL_ADDR)) begin
        alternate_hold_mode_reg <= req.wdata[pin_function_pkg::ALT_HOLD_BIT];
      end
      if (hit(req.addr, pin_function_pkg::INT_MASK_ADDR)) begin
        int_mask_reg <= req.wdata[pin_function_pkg::IRQ_WIDTH-1:0];
      end
    end
  end

  // Fault input and error combination
  // inverted input joins errors
  assign fault_input_level = (fault_mode == pin_function_pkg::FAULT_INPUT)
                             && !fault_sync_reg;
  assign any_error = (|internal_errors) || fault_input_level;

  always_ff @(posedge clk) begin
    if (rst) begin
      converter_fault <= 1'b0;
    end else begin
      converter_fault <= any_error;
    end
  end

  // Fault pin drive
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_pin       <= '0;
      fault_pullup_en <= 1'b0;
    end else begin
      case (fault_mode)
        pin_function_pkg::FAULT_OPEN_DRAIN: begin
          fault_pin.o     <= 1'b0;
          fault_pin.oe    <= any_error;
          fault_pullup_en <= 1'b0;
        end
        pin_function_pkg::FAULT_GP_OUTPUT: begin
          fault_pin.o     <= pin_config_reg[pin_function_pkg::FAULT_DATA_BIT];
          fault_pin.oe    <= 1'b1;
          fault_pullup_en <= 1'b1;
        end
        default: begin
          fault_pin       <= '0;
          fault_pullup_en <= 1'b0;
        end
      endcase
    end
  end

  // General outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      general_output_0    <= 1'b0;
      general_output_1    <= 1'b0;
      general_output_0_en <= 1'b0;
      general_output_1_en <= 1'b0;
    end else begin
      general_output_0_en <= pin_config_reg[pin_function_pkg::OUT_ENABLE_BIT];
      general_output_1_en <= pin_config_reg[pin_function_pkg::OUT_ENABLE_BIT];
      general_output_0 <= pin_config_reg[pin_function_pkg::OUT_ENABLE_BIT] &&
                          pin_config_reg[pin_function_pkg::OUT0_DATA_BIT];
      general_output_1 <= pin_config_reg[pin_function_pkg::OUT_ENABLE_BIT] &&
                          pin_config_reg[pin_function_pkg::OUT1_DATA_BIT];
    end
  end

  // Hold behaviour
  always_ff @(posedge clk) begin
    if (rst) begin
      converter_reset  <= 1'b0;
      start_conversion <= 1'b0;
      waiting_reg      <= 1'b0;
      hold_last_reg    <= 1'b1;
    end else begin
      hold_last_reg    <= hold_sync_reg;
      start_conversion <= 1'b0;
      converter_reset  <= 1'b0;
      if (!hold_enable) begin
        waiting_reg      <= 1'b0;
        start_conversion <= channel_switch_due;
      end else if (alt_active) begin
        if (waiting_reg) begin
          if (hold_sync_reg) begin
            waiting_reg      <= 1'b0;
            start_conversion <= 1'b1;
          end
        end else if (channel_switch_due) begin
          if (hold_sync_reg) begin
            start_conversion <= 1'b1;
          end else begin
            waiting_reg <= 1'b1;
          end
        end
      end else begin
        waiting_reg      <= 1'b0;
        converter_reset  <= !hold_sync_reg;
        start_conversion <= channel_switch_due && hold_sync_reg;
      end
    end
  end

  // Interrupt events: fault rise, hold fall, hold rise
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_last_reg <= 1'b0;
    end else begin
      fault_last_reg <= any_error;
    end
  end

  assign events[pin_function_pkg::IRQ_FAULT_BIT]     = any_error &&
                                                       !fault_last_reg;
  assign events[pin_function_pkg::IRQ_HOLD_FALL_BIT] = hold_last_reg &&
                                                       !hold_sync_reg;
  assign events[pin_function_pkg::IRQ_HOLD_RISE_BIT] = !hold_last_reg &&
                                                       hold_sync_reg;

  // Sticky status, read clears, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      int_status_reg <= '0;
    end else if (req.rd &&
                 hit(req.addr, pin_function_pkg::INT_STATUS_ADDR)) begin
      int_status_reg <= events;
    end else begin
      int_status_reg <= int_status_reg | events;
    end
  end

  assign irq = |(int_status_reg & int_mask_reg);

  // Read mux
  always_comb begin
    rdata_next = pin_function_pkg::ZERO_WORD;
    case (req.addr)
      pin_function_pkg::PIN_CONFIG_ADDR: begin
        rdata_next = pin_config_reg;
        if (fault_mode == pin_function_pkg::FAULT_INPUT) begin
          rdata_next[pin_function_pkg::FAULT_DATA_BIT] = fault_sync_reg;
        end
      end
      pin_function_pkg::INT_STATUS_ADDR: begin
        rdata_next[pin_function_pkg::IRQ_WIDTH-1:0] = int_status_reg;
      end
      pin_function_pkg::INT_MASK_ADDR: begin
        rdata_next[pin_function_pkg::IRQ_WIDTH-1:0] = int_mask_reg;
      end
      pin_function_pkg::HOLD_CTRL_ADDR: begin
        rdata_next[pin_function_pkg::ALT_HOLD_BIT] = alternate_hold_mode_reg;
      end
      default: begin
        rdata_next = pin_function_pkg::ZERO_WORD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= pin_function_pkg::ZERO_WORD;
    end else if (req.rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= pin_function_pkg::ZERO_WORD;
    end
  end

endmodule // pin_function_control

`default_nettype wire

// ---- include/pin_function_pkg.sv ----
// Package for the pin function control block: offsets, fields, resets.
// Assumes a 16-bit register space reached over a plain strobe port.
package pin_function_pkg;

  localparam logic [3:0] PIN_CONFIG_ADDR   = 4'h0;
  localparam logic [3:0] INT_STATUS_ADDR   = 4'h1;
  localparam logic [3:0] INT_MASK_ADDR     = 4'h2;
  localparam logic [3:0] HOLD_CTRL_ADDR    = 4'h3;

  localparam int OUT_ENABLE_BIT    = 13;
  localparam int HOLD_ENABLE_BIT   = 11;
  localparam int FAULT_MODE_HI     = 10;
  localparam int FAULT_MODE_LO     = 9;
  localparam int FAULT_DATA_BIT    = 8;
  localparam int OUT1_DATA_BIT     = 7;
  localparam int OUT0_DATA_BIT     = 6;
  localparam int ALT_HOLD_BIT      = 0;

  localparam logic [15:0] PIN_CONFIG_RESET = 16'h0800;
  localparam logic [15:0] PIN_CONFIG_WMASK = 16'h2FC0;
  localparam logic [15:0] ZERO_WORD        = 16'h0000;

  // Interrupt status layout
  localparam int IRQ_FAULT_BIT     = 0;
  localparam int IRQ_HOLD_FALL_BIT = 1;
  localparam int IRQ_HOLD_RISE_BIT = 2;
  localparam int IRQ_WIDTH         = 3;

  typedef enum logic [1:0] {
    FAULT_OFF,
    FAULT_INPUT,
    FAULT_OPEN_DRAIN,
    FAULT_GP_OUTPUT
  } fault_mode_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

endpackage : pin_function_pkg

// ---- sim/pin_function_chk.sv ----
// Port assertions for the pin function control block.
// Assumes one clock, synchronous active-high reset, bound to the top.
`timescale 1ns/1ps
`default_nettype none
module pin_function_chk #(
  parameter int ERR_WIDTH = 4
) (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire pin_function_pkg::reg_req_t   req,
  input wire logic [15:0]                  rdata,
  input wire logic                         hold_pin_n,
  input wire pin_function_pkg::pin_drive_t fault_pin,
  input wire logic                         fault_pullup_en,
  input wire logic                         general_output_0,
  input wire logic                         general_output_0_en,
  input wire logic                         general_output_1,
  input wire logic                         general_output_1_en,
  input wire logic [ERR_WIDTH-1:0]         internal_errors,
  input wire logic                         converter_reset,
  input wire logic                         start_conversion,
  input wire logic                         converter_fault
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence cfg_read_s;
    req.rd && req.addr == 4'h0;
  endsequence
  sequence err_held_s;
    (|internal_errors) ##1 (|internal_errors);
  endsequence
  chk_rsvd_zero: assert property (
    cfg_read_s |=> rdata[15:14] == 2'h0 && !rdata[12] && rdata[5:0] == 6'h00)
    else $error("reserved bits read nonzero");
  chk_hold_cause: assert property (
    $rose(converter_reset) |-> !$past(hold_pin_n, 2) ||
      !$past(hold_pin_n, 3) || !$past(hold_pin_n, 4))
    else $error("converter reset without low hold pin");
  chk_start_idle: assert property (
    start_conversion |-> !converter_reset)
    else $error("start while converter held");
  chk_general_output_0_gate: assert property (
    !general_output_0_en |-> !general_output_0)
    else $error("output 0 high while disabled");
  chk_general_output_1_gate: assert property (
    !general_output_1_en |-> !general_output_1)
    else $error("output 1 high while disabled");
  chk_en_pair: assert property (
    general_output_0_en == general_output_1_en)
    else $error("output enables differ");
  chk_od_low: assert property (
    fault_pin.oe && !fault_pullup_en |-> !fault_pin.o)
    else $error("open drain drove high");
  chk_pullup_drive: assert property (
    fault_pullup_en |-> fault_pin.oe)
    else $error("pull-up without drive");
  chk_err_flag: assert property (
    err_held_s |=> converter_fault)
    else $error("error not flagged");
  chk_reset_quiet: assert property (
    $past(rst) |-> !fault_pin.oe && !general_output_0_en && !converter_reset)
    else $error("outputs active after reset");
endmodule // pin_function_chk

bind pin_function_control pin_function_chk #(.ERR_WIDTH(ERR_WIDTH)) u_chk (
  .clk(clk), .rst(rst), .req(req), .rdata(rdata), .hold_pin_n(hold_pin_n),
  .fault_pin(fault_pin), .fault_pullup_en(fault_pullup_en),
  .general_output_0(general_output_0),
  .general_output_0_en(general_output_0_en),
  .general_output_1(general_output_1),
  .general_output_1_en(general_output_1_en),
  .internal_errors(internal_errors), .converter_reset(converter_reset),
  .start_conversion(start_conversion), .converter_fault(converter_fault));
`default_nettype wire

// ---- sim/fault_line_model.sv ----
// Board side of the fault pin: shared pulled-up line.
// Assumes another device may pull the line low.
`timescale 1ns/1ps
`default_nettype none
module fault_line_model (
  input wire pin_function_pkg::pin_drive_t drv,
  input wire logic                         pull_low,
  output logic                             level
);
  assign level = (drv.oe ? drv.o : 1'b1) & ~pull_low;
endmodule // fault_line_model
`default_nettype wire

// ---- sim/pin_function_control_tb.sv ----
// Testbench for the pin function control block.
// Assumes register port timing of one cycle read latency.
`timescale 1ns/1ps
`default_nettype none
module pin_function_control_tb;
  logic                         clk, rst, hold_n, pull_low, line, multi;
  logic                         due, pu, g0, g0e, g1, g1e, cres, start;
  logic                         fault, irq;
  logic [3:0]                   errs;
  logic [15:0]                  rdata, v;
  pin_function_pkg::reg_req_t   req;
  pin_function_pkg::pin_drive_t fpin;
  int                           bad_count, num_checks, n;

  pin_function_control dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .hold_pin_n(hold_n), .fault_pin_in(line), .fault_pin(fpin),
    .fault_pullup_en(pu), .general_output_0(g0), .general_output_0_en(g0e),
    .general_output_1(g1), .general_output_1_en(g1e), .multi_channel(multi),
    .channel_switch_due(due), .internal_errors(errs), .converter_reset(cres),
    .start_conversion(start), .converter_fault(fault), .irq(irq));
  fault_line_model pm (.drv(fpin), .pull_low(pull_low), .level(line));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string s, input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", s, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic count_start(input int c, output int k);
    k = 0;
    repeat (c) begin
      cyc(1);
      if (start === 1'b1) k++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    hold_n = 1'b1;
    {pull_low, multi, due} = 3'h0;
    errs = 4'h0;
    req = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, v); check("cfg_reset", v, 16'h0800);
    rd(4'hF, v); check("unmapped", v, 16'h0000);
    wr(4'h0, 16'hFFFF); rd(4'h0, v); check("cfg_rsvd", v, 16'h2FC0);
    cyc(2);
    check("general_output_0", g0, 16'h0001);
    check("general_output_1", g1, 16'h0001);
    check("gpo_en", {g0e, g1e}, 16'h0003);
    check("gp_line", {pu, line}, 16'h0003);
    $display("registers done");
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 16'h0940 | (16'(m) << 9)); cyc(3);
      check("fault_oe", fpin.oe, 16'(m == 3));
      check("gpo_off", {g0, g1}, 16'h0000);
      rd(4'h0, v); check("cfg_mode", v, 16'h0940 | (16'(m) << 9));
    end
    wr(4'h0, 16'h0800);
    @(posedge clk) pull_low <= 1'b1;
    cyc(4); check("off_fault", fault, 16'h0000);
    wr(4'h0, 16'h0B40); cyc(4); check("in_fault", fault, 16'h0001);
    rd(4'h0, v); check("in_read", v, 16'h0A40);
    @(posedge clk) pull_low <= 1'b0;
    wr(4'h0, 16'h0C00);
    @(posedge clk) errs <= 4'h1;
    cyc(3); check("od_low", {fault, line}, 16'h0002);
    @(posedge clk) errs <= 4'h0;
    cyc(3); check("od_free", line, 16'h0001);
    $display("fault pin done");
    wr(4'h0, 16'h0800);
    @(posedge clk) hold_n <= 1'b0;
    cyc(5); check("hold_rst", cres, 16'h0001);
    @(posedge clk) due <= 1'b1;
    @(posedge clk) due <= 1'b0;
    #1 check("hold_nostart", start, 16'h0000);
    @(posedge clk) hold_n <= 1'b1;
    cyc(5); check("hold_free", cres, 16'h0000);
    wr(4'h0, 16'h0000);
    @(posedge clk) hold_n <= 1'b0;
    cyc(5); check("hold_off", cres, 16'h0000);
    @(posedge clk) due <= 1'b1;
    @(posedge clk) due <= 1'b0;
    #1 check("off_start", start, 16'h0001);
    @(posedge clk) hold_n <= 1'b1;
    wr(4'h3, 16'h0001); wr(4'h0, 16'h0800);
    @(posedge clk) {multi, hold_n} <= 2'h2;
    cyc(5); check("alt_norst", cres, 16'h0000);
    @(posedge clk) due <= 1'b1;
    @(posedge clk) due <= 1'b0;
    count_start(6, n); check("alt_wait", 16'(n), 16'h0000);
    @(posedge clk) hold_n <= 1'b1;
    count_start(8, n); check("alt_go", 16'(n), 16'h0001);
    @(posedge clk) {multi, hold_n} <= 2'h0;
    cyc(5); check("alt_single", cres, 16'h0001);
    @(posedge clk) hold_n <= 1'b1;
    cyc(5);
    $display("hold pin done");
    rd(4'h1, v); wr(4'h2, 16'h0002);
    @(posedge clk) hold_n <= 1'b0;
    cyc(5); check("irq_set", irq, 16'h0001);
    rd(4'h1, v); check("sts_fall", v, 16'h0002);
    check("irq_clr", irq, 16'h0000);
    @(posedge clk) hold_n <= 1'b1;
    cyc(5); check("irq_mask", irq, 16'h0000);
    rd(4'h1, v); check("sts_rise", v, 16'h0004);
    $display("interrupts done");
    report_and_stop();
  end
endmodule // pin_function_control_tb
`default_nettype wire
